// ==== verilog/reset_brownout_supervisor.v ====
// Reset and brownout supervisor with wake-up timer
// ----------------------------------------------------------------
// Summary of operation
// - Pin, watchdog, power-on and brownout reset merge into one chip reset.
// - Any cause restarts wake-up timer; release waits pin, oscillator, count, flash.
// - On release the processor fetches from address zero, registers at reset values.
// - Supply below upper threshold raises brownout interrupt request to controller.
// - Upper-stage brownout indication is also readable as a status bit.
// - Supply below lower threshold forces chip reset.
// - Brownout reset holds to about 1 V; power-on detector covers below.
// - Both thresholds have hysteresis; assert and release levels differ.
// - Wake-up timer lets code start only once oscillator output is good.
// ----------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_defines.vh"
module reset_brownout_supervisor (
  input wire ref_clk,
  input wire rst,
  input wire reset_pin_n,
  input wire watchdog_rst,
  input wire por_detect,
  input wire brownout_upper_low,
  input wire brownout_upper_ok,
  input wire brownout_lower_low,
  input wire brownout_lower_ok,
  input wire osc_good,
  input wire flash_init_done,
  output reg chip_rst,
  output reg flash_init_start,
  output reg [31:0] fetch_addr,
  output reg core_run,
  output reg brownout_irq,
  output reg brownout_status,
  output reg brownout_reset_flag
);
  // ----------------------------------------------------------------
  // Brownout comparators with hysteresis
  // ----------------------------------------------------------------
  // Comparator pairs: low trips below threshold, ok only above the
  // threshold plus hysteresis; the latch holds between them.
  reg [1:0] up_low_sync_reg;
  reg [1:0] up_ok_sync_reg;
  reg [1:0] lo_low_sync_reg;
  reg [1:0] lo_ok_sync_reg;
  reg [1:0] pin_sync_reg;
  reg [1:0] osc_sync_reg;
  reg [1:0] flash_sync_reg;
  reg upper_state_reg;
  reg lower_state_reg;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      up_low_sync_reg <= 2'h0;
      up_ok_sync_reg <= 2'h0;
      lo_low_sync_reg <= 2'h0;
      lo_ok_sync_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
      osc_sync_reg <= 2'h0;
      flash_sync_reg <= 2'h0;
    end else begin
      up_low_sync_reg <= {up_low_sync_reg[0], brownout_upper_low};
      up_ok_sync_reg <= {up_ok_sync_reg[0], brownout_upper_ok};
      lo_low_sync_reg <= {lo_low_sync_reg[0], brownout_lower_low};
      lo_ok_sync_reg <= {lo_ok_sync_reg[0], brownout_lower_ok};
      pin_sync_reg <= {pin_sync_reg[0], reset_pin_n};
      osc_sync_reg <= {osc_sync_reg[0], osc_good};
      flash_sync_reg <= {flash_sync_reg[0], flash_init_done};
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upper_state_reg <= 1'b0;
    end else if (up_low_sync_reg[1]) begin
      upper_state_reg <= 1'b1;
    end else if (up_ok_sync_reg[1]) begin
      upper_state_reg <= 1'b0;
    end
  end

  // Lower stage latch: kept clear of the chip reset it causes
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lower_state_reg <= 1'b0;
    end else if (lo_low_sync_reg[1]) begin
      lower_state_reg <= 1'b1;
    end else if (lo_ok_sync_reg[1]) begin
      lower_state_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset merge
  // ----------------------------------------------------------------
  // The raw lower comparator joins the asynchronous term directly so a
  // deep sag resets at once even with a dying clock; power-on covers
  // the range where the comparator itself stops working.
  wire brownout_rst_async = brownout_lower_low | lower_state_reg;
  wire merged_async = rst | watchdog_rst | por_detect | brownout_rst_async;
  wire sync_rst;

  reset_sync u_reset_sync (
    .ref_clk(ref_clk),
    .async_rst(merged_async),
    .sync_rst(sync_rst)
  );

  // The pin is a synchronised level; a low pin restarts the sequence.
  wire seq_rst = sync_rst | ~pin_sync_reg[1];

  // ----------------------------------------------------------------
  // Wake-up sequencer
  // ----------------------------------------------------------------
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`OSC_QUAL_W-1:0] osc_cnt_reg;
  reg [`OSC_QUAL_W-1:0] osc_cnt_next;
  reg [`WAKE_CNT_W-1:0] wake_cnt_reg;
  reg [`WAKE_CNT_W-1:0] wake_cnt_next;

  always @* begin
    state_next = state_reg;
    osc_cnt_next = osc_cnt_reg;
    wake_cnt_next = wake_cnt_reg;
    case (state_reg)
      `ST_HOLD: begin
        osc_cnt_next = {`OSC_QUAL_W{1'b0}};
        wake_cnt_next = {`WAKE_CNT_W{1'b0}};
        state_next = `ST_OSC;
      end
      `ST_OSC: begin
        // A dropout restarts qualification rather than trusting one sample
        if (!osc_sync_reg[1]) begin
          osc_cnt_next = {`OSC_QUAL_W{1'b0}};
        end else if (osc_cnt_reg == `OSC_QUAL_COUNT - 8'h01) begin
          state_next = `ST_WAKE;
        end else begin
          osc_cnt_next = osc_cnt_reg + 8'h01;
        end
      end
      `ST_WAKE: begin
        if (!osc_sync_reg[1]) begin
          state_next = `ST_OSC;
          osc_cnt_next = {`OSC_QUAL_W{1'b0}};
          wake_cnt_next = {`WAKE_CNT_W{1'b0}};
        end else if (wake_cnt_reg == `WAKE_COUNT - 16'h0001) begin
          if (flash_sync_reg[1]) begin
            state_next = `ST_RUN;
          end
        end else begin
          wake_cnt_next = wake_cnt_reg + 16'h0001;
        end
      end
      `ST_RUN: begin
        state_next = `ST_RUN;
      end
      default: begin
        state_next = `ST_HOLD;
      end
    endcase
  end

  always @(posedge ref_clk or posedge seq_rst) begin
    if (seq_rst) begin
      state_reg <= `ST_HOLD;
      osc_cnt_reg <= {`OSC_QUAL_W{1'b0}};
      wake_cnt_reg <= {`WAKE_CNT_W{1'b0}};
    end else begin
      state_reg <= state_next;
      osc_cnt_reg <= osc_cnt_next;
      wake_cnt_reg <= wake_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge seq_rst) begin
    if (seq_rst) begin
      chip_rst <= 1'b1;
      flash_init_start <= 1'b0;
      fetch_addr <= `BOOT_ADDR;
      core_run <= 1'b0;
    end else begin
      chip_rst <= (state_next != `ST_RUN);
      flash_init_start <= (state_next == `ST_WAKE) || (state_next == `ST_RUN);
      fetch_addr <= `BOOT_ADDR;
      core_run <= (state_next == `ST_RUN);
    end
  end

  // Interrupt and status run off the plain reset so they survive
  // the brownout reset cycle and stay visible to software.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      brownout_irq <= 1'b0;
      brownout_status <= 1'b0;
      brownout_reset_flag <= 1'b0;
    end else begin
      brownout_irq <= upper_state_reg;
      brownout_status <= upper_state_reg;
      brownout_reset_flag <= lower_state_reg;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/supervisor_defines.vh ====
// Constants of the reset and brownout supervisor
`ifndef SUPERVISOR_DEFINES_VH
`define SUPERVISOR_DEFINES_VH
// Wake-up timer clock count after oscillator is judged good
`define WAKE_COUNT 16'h1000
`define WAKE_CNT_W 16
// Consecutive stable samples that qualify the oscillator
`define OSC_QUAL_COUNT 8'h40
`define OSC_QUAL_W 8
// Processor start address after release
`define BOOT_ADDR 32'h0000_0000
// Supervisor states
`define ST_HOLD 2'h0
`define ST_OSC 2'h1
`define ST_WAKE 2'h2
`define ST_RUN 2'h3
`endif

// ==== verilog/reset_sync.v ====
// Reset synchronizer: asynchronous assert, release on the clock
`timescale 1ns/100ps
`default_nettype none
module reset_sync (
  input wire ref_clk,
  input wire async_rst,
  output wire sync_rst
);
  reg meta_reg;
  reg hold_reg;
  // Release passes two flops so every register sees it on one edge
  always @(posedge ref_clk or posedge async_rst) begin
    if (async_rst) begin
      meta_reg <= 1'b1;
      hold_reg <= 1'b1;
    end else begin
      meta_reg <= 1'b0;
      hold_reg <= meta_reg;
    end
  end
  assign sync_rst = hold_reg;
endmodule
`default_nettype wire

// ==== bench/supervisor_properties.sv ====
// Checker of the reset and brownout supervisor ports
`timescale 1ns/100ps
`default_nettype none
module supervisor_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic watchdog_rst,
  input wire logic por_detect,
  input wire logic brownout_upper_low,
  input wire logic brownout_upper_ok,
  input wire logic brownout_lower_low,
  input wire logic osc_good,
  input wire logic flash_init_done,
  input wire logic chip_rst,
  input wire logic [31:0] fetch_addr,
  input wire logic core_run,
  input wire logic brownout_irq,
  input wire logic brownout_status,
  input wire logic brownout_reset_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_addr; fetch_addr == 32'h0; endproperty
  a_addr: assert property (p_addr) else $error("start address not zero");
  property p_run; core_run == !chip_rst; endproperty
  a_run: assert property (p_run) else $error("core run while in reset");
  property p_wdog; watchdog_rst |-> chip_rst; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog did not reset");
  property p_por; por_detect |-> chip_rst; endproperty
  a_por: assert property (p_por) else $error("power-on did not reset");
  property p_lower; brownout_lower_low |-> chip_rst; endproperty
  a_lower: assert property (p_lower) else $error("lower stage did not reset");
  property p_pin; !reset_pin_n |-> ##[0:4] chip_rst; endproperty
  a_pin: assert property (p_pin) else $error("pin did not reset");
  property p_rel; $fell(chip_rst) |-> flash_init_done && osc_good; endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_irq; $rose(brownout_upper_low) |-> ##[1:5] brownout_irq; endproperty
  a_irq: assert property (p_irq) else $error("no brownout request");
  property p_stat; brownout_status == brownout_irq; endproperty
  a_stat: assert property (p_stat) else $error("status differs");
  property p_hyst; (brownout_irq && !brownout_upper_ok)[*5] |=> brownout_irq; endproperty
  a_hyst: assert property (p_hyst) else $error("request dropped early");
  property p_flag; $rose(brownout_lower_low) |-> ##[1:5] brownout_reset_flag; endproperty
  a_flag: assert property (p_flag) else $error("no reset flag");
endmodule
bind reset_brownout_supervisor supervisor_props i_props (.*);
`default_nettype wire

// ==== bench/supply_model.sv ====
// Comparators, power-on detector and flash controller model
`timescale 1ns/100ps
`default_nettype none
module supply_model #(parameter int HYST_MV = 50) (
  input wire logic ref_clk,
  input wire logic [15:0] supply_mv,
  input wire logic flash_init_start,
  output logic brownout_upper_low,
  output logic brownout_upper_ok,
  output logic brownout_lower_low,
  output logic brownout_lower_ok,
  output logic por_detect,
  output logic flash_init_done
);
  logic [2:0] busy_reg;
  // Thresholds 2950 and 2650 mV, release above by HYST_MV
  assign brownout_upper_low = supply_mv < 16'hb86;
  assign brownout_upper_ok = supply_mv > 16'hb86 + HYST_MV;
  assign brownout_lower_low = supply_mv < 16'ha5a;
  assign brownout_lower_ok = supply_mv > 16'ha5a + HYST_MV;
  assign por_detect = supply_mv < 16'h3e8;
  // Flash init takes a few cycles and drops when start drops
  always @(posedge ref_clk) busy_reg <= {busy_reg[1:0], flash_init_start};
  assign flash_init_done = busy_reg[2] & flash_init_start;
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Testbench of the reset and brownout supervisor
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk = 0, rst = 1, reset_pin_n = 1, watchdog_rst = 0, osc_good = 1;
  logic [15:0] supply_mv = 16'hce4;
  logic upl, upo, lol, loo, por, fstart, fdone, chip_rst, core_run, irq, stat, flag;
  logic [31:0] fetch_addr;
  int n_mismatch = 0, samples_checked = 0, n;
  always #4 ref_clk = ~ref_clk;
  supply_model i_model (.ref_clk(ref_clk), .supply_mv(supply_mv), .flash_init_start(fstart),
    .brownout_upper_low(upl), .brownout_upper_ok(upo), .brownout_lower_low(lol),
    .brownout_lower_ok(loo), .por_detect(por), .flash_init_done(fdone));
  reset_brownout_supervisor i_dut (.ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .watchdog_rst(watchdog_rst), .por_detect(por), .brownout_upper_low(upl),
    .brownout_upper_ok(upo), .brownout_lower_low(lol), .brownout_lower_ok(loo),
    .osc_good(osc_good), .flash_init_done(fdone),
    .chip_rst(chip_rst), .flash_init_start(fstart), .fetch_addr(fetch_addr),
    .core_run(core_run), .brownout_irq(irq), .brownout_status(stat),
    .brownout_reset_flag(flag));
  task automatic complete_run;
    $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_run;
    n = 0;
    while (chip_rst !== 1'b0 && n < 6000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 6000) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic settle(input logic [15:0] mv);
    supply_mv = mv;
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic t_boot;
    wait_run();
    check(n > 4159, 1);
    check(fetch_addr, 32'h0);
    check(core_run, 1);
    $display("boot done");
  endtask
  task automatic t_bod;
    settle(16'hb54);
    check({irq, stat, chip_rst}, 3'h6);
    settle(16'hba4);
    check(irq, 1);
    settle(16'hce4);
    check(irq, 0);
    settle(16'ha28);
    check({chip_rst, flag}, 2'h3);
    settle(16'ha78);
    check({chip_rst, flag}, 2'h3);
    settle(16'hce4);
    wait_run();
    check(core_run, 1);
    $display("brownout done");
  endtask
  task automatic t_causes;
    for (int i = 0; i < 3; i++) begin
      reset_pin_n = (i != 0);
      watchdog_rst = (i == 1);
      supply_mv = (i == 2) ? 16'h384 : 16'hce4;
      repeat (4) @(negedge ref_clk);
      check({chip_rst, core_run, fstart}, 3'h4);
      reset_pin_n = 1;
      watchdog_rst = 0;
      supply_mv = 16'hce4;
      wait_run();
      check(n > 4159, 1);
    end
    $display("causes done");
  endtask
  task automatic t_osc;
    watchdog_rst = 1;
    @(negedge ref_clk);
    watchdog_rst = 0;
    repeat (2000) @(negedge ref_clk);
    osc_good = 0;
    repeat (10) @(negedge ref_clk);
    check(chip_rst, 1);
    osc_good = 1;
    wait_run();
    check(n > 4159, 1);
    $display("oscillator done");
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 0;
    t_boot();
    t_bod();
    t_causes();
    t_osc();
    complete_run();
  end
endmodule
`default_nettype wire
